// *** design/thm_irq.sv ***
// Sticky event status with write-one-to-clear and a pass mask.
// Assumes one-cycle event pulses and write strobes from the bus logic.
`timescale 1ns/1ps
`default_nettype none
module thm_irq
  import thm_pkg::*;
#(
  parameter int WIDTH = THM_NFLAG
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] event_set,
  input  wire logic             clear_we,
  input  wire logic             mask_we,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] status,
  output logic      [WIDTH-1:0] mask,
  output logic                  irq
);

  if (WIDTH < 1 || WIDTH > THM_REG_W) begin : g_bad_width
    $error("thm_irq: WIDTH must lie between one and the register width");
  end

  typedef struct packed {
    logic [WIDTH-1:0] status;
    logic [WIDTH-1:0] mask;
  } thm_irq_state_type;

  thm_irq_state_type st;
  thm_irq_state_type next_st;

  always_comb begin
    next_st = st;
    if (ce) begin
      // A new event beats a clear arriving in the same cycle
      next_st.status = (st.status & ~(clear_we ? wdata : '0)) | event_set;
      if (mask_we) begin
        next_st.mask = wdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign status = st.status;
  assign mask   = st.mask;
  assign irq    = |(st.status & st.mask);

  chk_irq_event_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && (event_set != '0)) |=> ((status & $past(event_set)) != '0))
    else $error("event did not set its status bit");

endmodule
`default_nettype wire

// *** design/thm_monitor.sv ***
// Thermal protection monitor: sensor flags, auto shutdown, APB registers.
// Assumes raw comparator levels from two on-chip temperature sensors and
// output enable settings held in registers elsewhere in the device.
//
// Summary of operation
// - Disabled sensor yields no warning or error
// - Warning flag follows sensor warning comparator
// - Error flag follows sensor error comparator
// - Shutdown forces both speaker enables low
// - Shutdown forces charge pump enable low
// - Either error flag shuts down everything
// - Enables return to settings when error clears
// - Auto shutdown enable bit, resets enabled
// - Read-only status flags at 2Fh
// - Sensor enables at 30h, reset enabled
// - Temperature status available for GPIO
// - Flags raise interrupt events
`timescale 1ns/1ps
`default_nettype none
module thm_monitor
  import thm_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [THM_ADDR_W-1:0] paddr,
  input  wire logic [THM_DATA_W-1:0] pwdata,
  output logic      [THM_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire thm_flags_type         sensor_raw,
  input  wire thm_out_en_type        out_en_setting,
  output thm_out_en_type             out_en,
  output logic                       temp_status_gpio,
  output logic                       irq
);

  thm_core_state_type   st;
  thm_core_state_type   next_st;
  thm_flags_type        sensor_sync;
  thm_flags_type        flags;
  logic [THM_NFLAG-1:0] irq_status;
  logic [THM_NFLAG-1:0] irq_mask;
  logic [THM_NFLAG-1:0] flag_rise;
  logic [5:0]           idx;
  logic                 aligned;
  logic                 mapped;
  logic                 xfer_done;
  logic                 wr_done;
  logic                 shut_cond;
  logic [THM_REG_W-1:0] rd_mux;

  thm_sync #(
    .WIDTH (THM_NFLAG)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d_async (sensor_raw),
    .q       (sensor_sync)
  );

  // Flags are live views of the synchronised comparators, gated by enable
  always_comb begin
    flags                  = sensor_sync;
    flags.hp_error_flag    = sensor_sync.hp_error_flag
                             & st.hp_sensor_enable;
    flags.hp_warning_flag  = sensor_sync.hp_warning_flag
                             & st.hp_sensor_enable;
    flags.spk_error_flag   = sensor_sync.spk_error_flag
                             & st.spk_sensor_enable;
    flags.spk_warning_flag = sensor_sync.spk_warning_flag
                             & st.spk_sensor_enable;
  end

  // Either error trips the whole output stage; with both sensors off the
  // error flags stay low, so shutdown cannot act
  assign shut_cond = st.auto_shutdown_enable
                     & (flags.hp_error_flag
                        | flags.spk_error_flag);

  // Only a new trip is an event, so a hot die does not refire constantly
  assign flag_rise = flags & ~st.prev_flags;

  assign temp_status_gpio = flags.hp_error_flag
                            | flags.spk_error_flag;

  // APB decode
  assign idx     = paddr[7:2];
  assign aligned = (paddr[1:0] == THM_ALIGN);

  always_comb begin
    mapped = 1'b0;
    rd_mux = '0;
    case (idx)
      THM_IDX_SHUTDOWN: begin
        mapped = aligned;
        rd_mux[THM_BIT_AUTO] = st.auto_shutdown_enable;
      end
      THM_IDX_STATUS: begin
        mapped = aligned;
        rd_mux[THM_NFLAG-1:0] = flags;
      end
      THM_IDX_SENSOR_EN: begin
        mapped = aligned;
        rd_mux[THM_BIT_HP_EN]  = st.hp_sensor_enable;
        rd_mux[THM_BIT_SPK_EN] = st.spk_sensor_enable;
      end
      THM_IDX_IRQ_STAT: begin
        mapped = aligned;
        rd_mux[THM_NFLAG-1:0] = irq_status;
      end
      THM_IDX_IRQ_MASK: begin
        mapped = aligned;
        rd_mux[THM_NFLAG-1:0] = irq_mask;
      end
      default: begin
        mapped = 1'b0;
        rd_mux = '0;
      end
    endcase
  end

  // Read data is captured on the first cycle with psel; the access phase
  // then completes at once, giving zero wait states while ce is high
  assign pready    = penable & st.armed & ce;
  assign xfer_done = psel & pready;
  assign wr_done   = xfer_done & pwrite & mapped;

  always_comb begin
    next_st = st;
    if (ce) begin
      if (psel && !st.armed) begin
        next_st.armed  = 1'b1;
        next_st.slverr = !mapped;
        next_st.rdata  = pwrite ? '0 : rd_mux;
      end
      if (xfer_done) begin
        next_st.armed = 1'b0;
      end
      // Status register is read-only; writes to it are dropped
      if (wr_done && idx == THM_IDX_SHUTDOWN) begin
        next_st.auto_shutdown_enable = pwdata[THM_BIT_AUTO];
      end
      if (wr_done && idx == THM_IDX_SENSOR_EN) begin
        next_st.hp_sensor_enable  = pwdata[THM_BIT_HP_EN];
        next_st.spk_sensor_enable = pwdata[THM_BIT_SPK_EN];
      end
      next_st.prev_flags = flags;
      case (st.mode)
        THM_RUN: begin
          if (shut_cond) begin
            next_st.mode = THM_SHUT;
          end
        end
        THM_SHUT: begin
          if (!shut_cond) begin
            next_st.mode = THM_RUN;
          end
        end
        default: begin
          next_st.mode = THM_RUN;
        end
      endcase
      // Settings registers stay untouched, so leaving shutdown restores
      // exactly what software had programmed
      if (next_st.mode == THM_SHUT) begin
        next_st.out_en = '0;
      end else begin
        next_st.out_en = out_en_setting;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st                      <= '0;
      st.mode                 <= THM_RUN;
      st.auto_shutdown_enable <= THM_RST_AUTO;
      st.hp_sensor_enable     <= THM_RST_HP_EN;
      st.spk_sensor_enable    <= THM_RST_SPK_EN;
    end else begin
      st <= next_st;
    end
  end

  thm_irq #(
    .WIDTH (THM_NFLAG)
  ) u_irq (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .event_set (flag_rise),
    .clear_we  (wr_done && idx == THM_IDX_IRQ_STAT),
    .mask_we   (wr_done && idx == THM_IDX_IRQ_MASK),
    .wdata     (pwdata[THM_NFLAG-1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  assign prdata  = {{(THM_DATA_W-THM_REG_W){1'b0}}, st.rdata};
  assign pslverr = st.slverr & pready;
  assign out_en  = st.out_en;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_disabled_sensor_quiet: assert property (
    (!st.hp_sensor_enable |-> !flags.hp_error_flag && !flags.hp_warning_flag)
    and (!st.spk_sensor_enable |->
         !flags.spk_error_flag && !flags.spk_warning_flag))
    else $error("disabled sensor shows a flag");

  chk_warn_flag_follow: assert property (
    (st.hp_sensor_enable && sensor_sync.hp_warning_flag)
    |-> flags.hp_warning_flag)
    else $error("headphone warning flag missing");

  chk_err_flag_follow: assert property (
    (st.spk_sensor_enable && sensor_sync.spk_error_flag)
    |-> flags.spk_error_flag)
    else $error("speaker error flag missing");

  chk_speaker_shutdown: assert property (
    (ce && shut_cond) |=>
    !out_en.left_speaker_enable && !out_en.right_speaker_enable)
    else $error("speakers still enabled in over-temperature");

  chk_pump_shutdown: assert property (
    (ce && st.auto_shutdown_enable && flags.spk_error_flag)
    |=> !out_en.charge_pump_enable)
    else $error("charge pump still enabled after speaker error");

  chk_restore_settings: assert property (
    (ce && st.mode == THM_SHUT && !shut_cond)
    |=> (out_en == $past(out_en_setting)) && st.mode == THM_RUN)
    else $error("enables not restored after cooling");

  chk_auto_off_runs: assert property (
    (ce && !st.auto_shutdown_enable) |=> st.mode == THM_RUN)
    else $error("shutdown active while auto shutdown is off");

  chk_status_read: assert property (
    (ce && psel && !penable && !st.armed && !pwrite
     && paddr == {THM_IDX_STATUS, THM_ALIGN})
    |=> prdata[THM_NFLAG-1:0] == $past(flags))
    else $error("status read does not return the flags");

  chk_flag_not_latched: assert property (
    (!sensor_sync.hp_error_flag && !sensor_sync.spk_error_flag)
    |-> !temp_status_gpio)
    else $error("error status held after condition left");

  chk_hp_err_shuts_all: assert property (
    (ce && st.auto_shutdown_enable && flags.hp_error_flag)
    |=> out_en == '0)
    else $error("outputs still enabled after headphone error");

  chk_hp_err_follow: assert property (
    (st.hp_sensor_enable && sensor_sync.hp_error_flag)
    |-> flags.hp_error_flag)
    else $error("headphone error flag missing");

  chk_spk_warn_follow: assert property (
    (st.spk_sensor_enable && sensor_sync.spk_warning_flag)
    |-> flags.spk_warning_flag)
    else $error("speaker warning flag missing");

  chk_gpio_error_status: assert property (
    ((st.hp_sensor_enable && sensor_sync.hp_error_flag)
     || (st.spk_sensor_enable && sensor_sync.spk_error_flag))
    |-> temp_status_gpio)
    else $error("status pin low while an error flag is up");

  // Register writes land at the completing edge of the access phase
  chk_sensor_en_write: assert property (
    (ce && psel && penable && pready && pwrite
     && paddr == {THM_IDX_SENSOR_EN, THM_ALIGN})
    |=> st.hp_sensor_enable == $past(pwdata[THM_BIT_HP_EN])
        && st.spk_sensor_enable == $past(pwdata[THM_BIT_SPK_EN]))
    else $error("sensor enable write did not land");

  chk_auto_write: assert property (
    (ce && psel && penable && pready && pwrite
     && paddr == {THM_IDX_SHUTDOWN, THM_ALIGN})
    |=> st.auto_shutdown_enable == $past(pwdata[THM_BIT_AUTO]))
    else $error("auto shutdown write did not land");

  chk_error_rise_event: assert property (
    (ce && flags.hp_error_flag && !st.prev_flags.hp_error_flag)
    |=> irq_status[THM_BIT_HP_ERR])
    else $error("headphone error rise raised no event");

  chk_follow_setting: assert property (
    (ce && st.mode == THM_RUN && !shut_cond)
    |=> out_en == $past(out_en_setting))
    else $error("enables do not follow settings in normal run");

endmodule
`default_nettype wire

// *** design/thm_pkg.sv ***
// Shared constants and carrier types of the thermal protection monitor.
// Assumes a 32-bit APB register bus with word-aligned registers.
package thm_pkg;

  // Clock and bus geometry
  localparam int THM_CLK_HZ   = 40_000_000;
  localparam int THM_ADDR_W   = 8;
  localparam int THM_DATA_W   = 32;
  localparam int THM_REG_W    = 16;
  localparam int THM_NFLAG    = 4;
  localparam int THM_SYNC_N   = 2;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] THM_IDX_SHUTDOWN  = 6'h17;
  localparam logic [5:0] THM_IDX_STATUS    = 6'h2f;
  localparam logic [5:0] THM_IDX_SENSOR_EN = 6'h30;
  localparam logic [5:0] THM_IDX_IRQ_STAT  = 6'h31;
  localparam logic [5:0] THM_IDX_IRQ_MASK  = 6'h32;
  localparam logic [1:0] THM_ALIGN         = 2'h0;

  // Field positions
  localparam int THM_BIT_AUTO     = 8;
  localparam int THM_BIT_HP_ERR   = 3;
  localparam int THM_BIT_HP_WARN  = 2;
  localparam int THM_BIT_SPK_ERR  = 1;
  localparam int THM_BIT_SPK_WARN = 0;
  localparam int THM_BIT_HP_EN    = 2;
  localparam int THM_BIT_SPK_EN   = 1;

  // Reset values
  localparam logic THM_RST_AUTO   = 1'h1;
  localparam logic THM_RST_HP_EN  = 1'h1;
  localparam logic THM_RST_SPK_EN = 1'h1;

  // Field order matches status bits 3..0
  typedef struct packed {
    logic hp_error_flag;
    logic hp_warning_flag;
    logic spk_error_flag;
    logic spk_warning_flag;
  } thm_flags_type;

  typedef struct packed {
    logic left_speaker_enable;
    logic right_speaker_enable;
    logic charge_pump_enable;
  } thm_out_en_type;

  typedef enum logic [0:0] {
    THM_RUN  = 1'b0,
    THM_SHUT = 1'b1
  } thm_mode_type;

  typedef struct packed {
    thm_mode_type          mode;
    logic                  auto_shutdown_enable;
    logic                  hp_sensor_enable;
    logic                  spk_sensor_enable;
    thm_flags_type         prev_flags;
    thm_out_en_type        out_en;
    logic                  armed;
    logic                  slverr;
    logic [THM_REG_W-1:0]  rdata;
  } thm_core_state_type;

endpackage

// *** design/thm_sync.sv ***
// Two-flop synchroniser for a vector of independent level signals.
// Assumes each bit changes slowly against the clock; no bus coherency.
`timescale 1ns/1ps
`default_nettype none
module thm_sync
  import thm_pkg::*;
#(
  parameter int WIDTH = THM_NFLAG
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d_async,
  output logic      [WIDTH-1:0] q
);

  if (WIDTH < 1) begin : g_bad_width
    $error("thm_sync: WIDTH must be at least one");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } thm_sync_state_type;

  thm_sync_state_type st;
  thm_sync_state_type next_st;

  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.meta   = d_async;
      next_st.stable = st.meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.stable;

  chk_sync_two_stage: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce ##1 ce) |=> (q == $past(d_async, 2)))
    else $error("synchroniser output is not the input two edges late");

endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the thermal monitor over APB.
// Assumes zero or more wait states; ce dropped once to check freezing.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import thm_pkg::*;
;
  logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic           ce = 1'b1;
  logic [7:0]     paddr = 8'h00, hp_deg = 8'd25, spk_deg = 8'd25;
  logic [31:0]    pwdata = 32'h0000_0000, prdata, rd;
  logic           pready, pslverr, err, gpio, irq;
  thm_flags_type  raw;
  thm_out_en_type set_en, oe;
  int             mismatches = 0, checked = 0, cyc = 0;
  localparam logic [7:0] A_CTL = {THM_IDX_SHUTDOWN, THM_ALIGN};
  localparam logic [7:0] A_ST  = {THM_IDX_STATUS, THM_ALIGN};
  localparam logic [7:0] A_EN  = {THM_IDX_SENSOR_EN, THM_ALIGN};
  localparam logic [7:0] A_IS  = {THM_IDX_IRQ_STAT, THM_ALIGN};
  localparam logic [7:0] A_IM  = {THM_IDX_IRQ_MASK, THM_ALIGN};
  localparam logic [2:0] SET   = 3'h5;

  always #12.5 pclk = ~pclk;

  thm_sensor_model u_thm_sensor_model (.hp_deg(hp_deg), .spk_deg(spk_deg),
    .setting(set_en), .sensor_raw(raw), .out_en_setting());
  thm_monitor u_thm_monitor (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensor_raw(raw), .out_en_setting(set_en), .out_en(oe),
    .temp_status_gpio(gpio), .irq(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Release happens at the completing edge; the next setup waits one edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) chk(1'b0, 1'b1, "pready timeout");
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & m, exp, what);
  endtask

  task automatic heat(input logic [7:0] h, input logic [7:0] s);
    @(posedge pclk);
    hp_deg <= h;
    spk_deg <= s;
    repeat (6) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    set_en = SET;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rdchk(A_CTL, 32'h0000_0100, 32'h0000_0100, "auto reset");
    rdchk(A_EN, 32'h0000_0006, 32'h0000_0006, "sensor en reset");
    rdchk(A_ST, 32'h0000_000f, 32'h0000_0000, "status reset");
    $display("test reset done");
    heat(8'd150, 8'd25);
    rdchk(A_ST, 32'h0000_000f, 32'h0000_000c, "hp err+warn");
    chk({29'h0, oe}, 32'h0000_0000, "hp shutdown");
    chk({31'h0, gpio}, 32'h0000_0001, "gpio hot");
    rdchk(A_IS, 32'h0000_000f, 32'h0000_000c, "irq status");
    chk({31'h0, irq}, 32'h0000_0000, "irq masked");
    apb(1'b1, A_IM, 32'h0000_000f);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001, "irq unmasked");
    apb(1'b1, A_IS, 32'h0000_000f);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
    apb(1'b1, A_ST, 32'h0000_0000);
    rdchk(A_ST, 32'h0000_000f, 32'h0000_000c, "status read only");
    @(posedge pclk);
    ce <= 1'b0;
    heat(8'd100, 8'd25);
    chk({29'h0, oe}, 32'h0000_0000, "ce low freezes outputs");
    chk({31'h0, gpio}, 32'h0000_0001, "ce low freezes flags");
    ce <= 1'b1;
    repeat (4) @(posedge pclk);
    rdchk(A_ST, 32'h0000_000f, 32'h0000_0000, "hp cooled");
    chk({29'h0, oe}, {29'h0, SET}, "restore");
    chk({31'h0, gpio}, 32'h0000_0000, "gpio cool");
    $display("test hp overheat done");
    heat(8'd25, 8'd130);
    rdchk(A_ST, 32'h0000_000f, 32'h0000_0001, "spk warn");
    chk({29'h0, oe}, {29'h0, SET}, "warn keeps outputs");
    heat(8'd25, 8'd150);
    rdchk(A_ST, 32'h0000_000f, 32'h0000_0003, "spk err");
    chk({29'h0, oe}, 32'h0000_0000, "spk shuts all");
    rdchk(A_IS, 32'h0000_000f, 32'h0000_0003, "spk events");
    chk({31'h0, irq}, 32'h0000_0001, "irq spk");
    apb(1'b1, A_EN, 32'h0000_0004);
    repeat (4) @(posedge pclk);
    rdchk(A_ST, 32'h0000_000f, 32'h0000_0000, "spk disabled");
    chk({29'h0, oe}, {29'h0, SET}, "disabled restores");
    $display("test spk overheat done");
    apb(1'b1, A_CTL, 32'h0000_0000);
    rdchk(A_CTL, 32'h0000_0100, 32'h0000_0000, "auto off");
    heat(8'd150, 8'd150);
    rdchk(A_ST, 32'h0000_000f, 32'h0000_000c, "hp err no auto");
    chk({29'h0, oe}, {29'h0, SET}, "no auto no shutdown");
    apb(1'b0, 8'hf0, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001, "unmapped error");
    $display("test controls done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** test/thm_sensor_model.sv ***
// Behavioural model of the two on-chip temperature sensors and the
// programmed output enables. Assumes temperatures in whole degrees.
`timescale 1ns/1ps
`default_nettype none
module thm_sensor_model
  import thm_pkg::*;
(
  input  wire logic [7:0]     hp_deg,
  input  wire logic [7:0]     spk_deg,
  input  wire thm_out_en_type setting,
  output thm_flags_type       sensor_raw,
  output thm_out_en_type      out_en_setting
);
  // Comparators are level outputs; warning band starts at 125 degrees
  always_comb begin
    sensor_raw.hp_warning_flag  = hp_deg >= 8'h7d;
    sensor_raw.spk_warning_flag = spk_deg >= 8'h7d;
    sensor_raw.hp_error_flag    = hp_deg > 8'h91;
    sensor_raw.spk_error_flag   = spk_deg > 8'h91;
    out_en_setting              = setting;
  end
endmodule
`default_nettype wire
